/* File: phy_port_defines.svh */
// register offsets, field positions, reset values and timing figures
`ifndef PHY_PORT_DEFINES_SVH
`define PHY_PORT_DEFINES_SVH

// ==========================================
// register offsets
`define REG_QUICK_STATUS 5'h11
`define REG_INT_ENABLE 5'h12
`define REG_INT_STATUS 5'h13
`define REG_LED_CONFIG 5'h14
`define REG_TX_CTRL_ONE 5'h1c
`define REG_TX_CTRL_TWO 5'h1e

// ==========================================
// quick status bits
`define QS_SPEED_BIT 14
`define QS_TX_BIT 13
`define QS_RX_BIT 12
`define QS_COL_BIT 11
`define QS_LINK_BIT 10
`define QS_DUPLEX_BIT 9
`define QS_ANEG_MODE_BIT 8
`define QS_ANEG_DONE_BIT 7
`define QS_POLARITY_BIT 5
`define QS_PAUSE_BIT 4
`define QS_ERROR_BIT 3

// ==========================================
// interrupt enable and status fields
`define IE_MASK_LSB 4
`define IE_MASTER_BIT 1
`define IE_TEST_BIT 0
`define IS_EVENT_LSB 4
`define IS_PENDING_BIT 2
`define IE_RESET 4'h0

// ==========================================
// led configuration fields
`define LED1_LSB 12
`define LED2_LSB 8
`define LED3_LSB 4
`define LED_LEN_LSB 2
`define LED_STRETCH_BIT 1
`define LED1_RESET 4'h0
`define LED2_RESET 4'h4
`define LED3_RESET 4'h2
`define LED_LEN_RESET 2'h0
`define LED_STRETCH_RESET 1'b1
`define TX_CTRL_RESET 16'h0000

// ==========================================
// led selector codes
`define LED_SPEED 4'h0
`define LED_TX 4'h1
`define LED_RX 4'h2
`define LED_COL 4'h3
`define LED_LINK 4'h4
`define LED_DUPLEX 4'h5
`define LED_ACT 4'h7
`define LED_ON 4'h8
`define LED_OFF 4'h9
`define LED_FAST 4'ha
`define LED_SLOW 4'hb
`define LED_LINK_RX 4'hc
`define LED_LINK_ACT 4'hd
`define LED_DPX_COL 4'he

// ==========================================
// timing
`define CLK_FREQ_KHZ 40000
`define STRETCH0_MS 30
`define STRETCH1_MS 60
`define STRETCH2_MS 100
`define FAST_BLINK_MS 100
`define SLOW_BLINK_MS 500
`define PREAMBLE_BITS 32

`endif

/* File: phy_port_pkg.sv */
// types shared by the port management register block
package phy_port_pkg;

	typedef struct packed {
		logic speed_100;
		logic tx_active;
		logic rx_active;
		logic collision;
		logic link_up;
		logic full_duplex;
		logic aneg_enabled;
		logic aneg_done;
		logic polarity_reversed;
		logic pause_advertised;
		logic error_seen;
	} port_status_s;

	typedef enum logic [2:0] {
		MD_PREAMBLE,
		MD_HEADER,
		MD_TA_READ,
		MD_TA_WRITE,
		MD_DATA_READ,
		MD_DATA_WRITE
	} mdio_state_e;

endpackage

/* File: phy_port_status_irq_led_regs.sv */
// per-port quick status, interrupt and led register logic behind the mdio port
// What this block does
// - quick status shows live collision, link up and full duplex
// - quick status shows negotiation mode and completion, same as basic status
// - polarity bit reads one when receive pair polarity is reversed
// - pause bit mirrors the advertised local pause capability
// - error bit reads one once an error such as remote fault occurred
// - four mask bits gate negotiation, speed, duplex, link events; reset zero
// - master enable bit allows the port interrupt; resets to zero
// - test bit forces the management interrupt on
// - speed, duplex, link change bits latch and clear on read
// - negotiation done bit latches and clears on read
// - pending bit shows a pending interrupt and clears on read
// - self clearing status bits clear on a management read of the interrupt status register
// - led selector codes pick speed, tx, rx, collision, link, duplex, activity
// - codes 1000 to 1011 force on, off, fast and slow blink
// - combined codes show primary solid and toggle on secondary events
// - combined displays are always stretched
// - three led selectors with reset values speed, link, receive
// - stretch length field selects 30, 60 or 100 ms
// - stretch enable bit resets to one
// - duplex led may stay on briefly after link loss
`timescale 1ns/10ps
`include "phy_port_defines.svh"

module phy_port_status_irq_led_regs
	import phy_port_pkg::*;
#(
	parameter int STRETCH0_CYCLES = `STRETCH0_MS * `CLK_FREQ_KHZ,
	parameter int STRETCH1_CYCLES = `STRETCH1_MS * `CLK_FREQ_KHZ,
	parameter int STRETCH2_CYCLES = `STRETCH2_MS * `CLK_FREQ_KHZ,
	parameter int FAST_BLINK_CYCLES = `FAST_BLINK_MS * `CLK_FREQ_KHZ,
	parameter int SLOW_BLINK_CYCLES = `SLOW_BLINK_MS * `CLK_FREQ_KHZ,
	parameter bit LED_ACTIVE_LOW = 1'b1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [4:0] phy_address,
	input wire port_status_s port_status,
	input wire logic mdc,
	input wire logic mdio_in,
	output logic mdio_out,
	output logic mdio_oe,
	output logic management_interrupt_pending_n,
	output logic [2:0] led
);

	// wide enough for the slow blink default, which needs 25 bits
	localparam int CW = 32;

	// ==========================================
	// management frame decoder
	mdio_state_e st_ff, nxt_st;
	logic [5:0] cnt_ff, nxt_cnt;
	logic [15:0] sh_ff, nxt_sh;
	logic [4:0] reg_ff, nxt_reg;
	logic mdc_ff, out_ff, nxt_out, oe_ff, nxt_oe, match_ff, nxt_match;
	logic mdc_rise, rd_strobe, wr_strobe;
	logic [15:0] rd_data;

	// register state
	logic [3:0] mask_ff, nxt_mask;
	logic port_interrupt_master_enable_ff, nxt_port_interrupt_master_enable, force_interrupt_test_ff, nxt_force_interrupt_test;
	logic [3:0] ev_ff, nxt_ev;
	logic pend_ff, nxt_pend;
	logic [3:0] sel_ff [3];
	logic [3:0] nxt_sel [3];
	logic [1:0] len_ff, nxt_len;
	logic str_en_ff, nxt_str_en;
	logic [15:0] txc1_ff, nxt_txc1, txc2_ff, nxt_txc2;
	logic spd_prev_ff, dpx_prev_ff, lnk_prev_ff, ang_prev_ff;
	logic irq_n_ff, nxt_irq_n;
	logic irq_cond;
	logic [3:0] ev_set;

	// led state
	logic [CW-1:0] scnt_ff [3];
	logic [CW-1:0] nxt_scnt [3];
	logic [CW-1:0] fast_ff, nxt_fast, slow_ff, nxt_slow;
	logic fast_ph_ff, nxt_fast_ph, slow_ph_ff, nxt_slow_ph;
	logic [2:0] led_ff, nxt_led;

	function automatic logic [CW-1:0] stretch_len(input logic [1:0] code);
		unique case (code)
			2'b00: stretch_len = CW'(STRETCH0_CYCLES);
			2'b01: stretch_len = CW'(STRETCH1_CYCLES);
			default: stretch_len = CW'(STRETCH2_CYCLES);
		endcase
	endfunction

	assign mdc_rise = mdc & ~mdc_ff;

	// ==========================================
	// read data mux
	always_comb begin
		rd_data = 16'h0000;
		unique case (reg_ff)
			`REG_QUICK_STATUS: begin
				rd_data[`QS_SPEED_BIT] = port_status.speed_100;
				rd_data[`QS_TX_BIT] = port_status.tx_active;
				rd_data[`QS_RX_BIT] = port_status.rx_active;
				rd_data[`QS_COL_BIT] = port_status.collision;
				rd_data[`QS_LINK_BIT] = port_status.link_up;
				rd_data[`QS_DUPLEX_BIT] = port_status.full_duplex;
				rd_data[`QS_ANEG_MODE_BIT] = port_status.aneg_enabled;
				rd_data[`QS_ANEG_DONE_BIT] = port_status.aneg_done;
				rd_data[`QS_POLARITY_BIT] = port_status.polarity_reversed;
				rd_data[`QS_PAUSE_BIT] = port_status.pause_advertised;
				rd_data[`QS_ERROR_BIT] = port_status.error_seen;
			end
			`REG_INT_ENABLE: begin
				rd_data[`IE_MASK_LSB +: 4] = mask_ff;
				rd_data[`IE_MASTER_BIT] = port_interrupt_master_enable_ff;
				rd_data[`IE_TEST_BIT] = force_interrupt_test_ff;
			end
			`REG_INT_STATUS: begin
				rd_data[`IS_EVENT_LSB +: 4] = ev_ff;
				rd_data[`IS_PENDING_BIT] = pend_ff;
			end
			`REG_LED_CONFIG: begin
				rd_data[`LED1_LSB +: 4] = sel_ff[0];
				rd_data[`LED2_LSB +: 4] = sel_ff[1];
				rd_data[`LED3_LSB +: 4] = sel_ff[2];
				rd_data[`LED_LEN_LSB +: 2] = len_ff;
				rd_data[`LED_STRETCH_BIT] = str_en_ff;
			end
			`REG_TX_CTRL_ONE: rd_data = txc1_ff;
			`REG_TX_CTRL_TWO: rd_data = txc2_ff;
			default: rd_data = 16'h0000;
		endcase
	end

	// ==========================================
	// mdio frame sequencer, mdc sampled as a plain input
	always_comb begin
		nxt_st = st_ff;
		nxt_cnt = cnt_ff;
		nxt_sh = sh_ff;
		nxt_reg = reg_ff;
		nxt_out = out_ff;
		nxt_oe = oe_ff;
		nxt_match = match_ff;
		rd_strobe = 1'b0;
		wr_strobe = 1'b0;
		if (mdc_rise) begin
			unique case (st_ff)
				MD_PREAMBLE: begin
					if (mdio_in) begin
						if (cnt_ff != 6'(`PREAMBLE_BITS))
							nxt_cnt = cnt_ff + 6'h01;
					end else if (cnt_ff == 6'(`PREAMBLE_BITS)) begin
						nxt_st = MD_HEADER;
						nxt_cnt = 6'h00;
					end else begin
						nxt_cnt = 6'h00;
					end
				end
				MD_HEADER: begin
					// start bit, opcode, phy address, register address
					nxt_sh = {sh_ff[14:0], mdio_in};
					nxt_cnt = cnt_ff + 6'h01;
					if (cnt_ff == 6'd12) begin
						nxt_reg = {sh_ff[3:0], mdio_in};
						nxt_match = (sh_ff[8:4] == phy_address);
						nxt_cnt = 6'h00;
						if (sh_ff[11:9] == 3'b110 || sh_ff[11:9] == 3'b101)
							nxt_st = (sh_ff[10]) ? MD_TA_READ : MD_TA_WRITE;
						else
							nxt_st = MD_PREAMBLE;
					end
				end
				MD_TA_READ: begin
					// capture read data; self clearing bits go with it
					nxt_sh = rd_data;
					rd_strobe = match_ff;
					nxt_out = 1'b0;
					nxt_oe = match_ff;
					nxt_st = MD_DATA_READ;
				end
				MD_DATA_READ: begin
					nxt_cnt = cnt_ff + 6'h01;
					nxt_out = sh_ff[15];
					nxt_sh = {sh_ff[14:0], 1'b0};
					if (cnt_ff == 6'd16) begin
						nxt_oe = 1'b0;
						nxt_out = 1'b0;
						nxt_cnt = 6'h00;
						nxt_st = MD_PREAMBLE;
					end
				end
				MD_TA_WRITE: begin
					nxt_cnt = cnt_ff + 6'h01;
					if (cnt_ff == 6'd1) begin
						nxt_cnt = 6'h00;
						nxt_st = MD_DATA_WRITE;
					end
				end
				MD_DATA_WRITE: begin
					nxt_sh = {sh_ff[14:0], mdio_in};
					nxt_cnt = cnt_ff + 6'h01;
					if (cnt_ff == 6'd15) begin
						wr_strobe = match_ff;
						nxt_cnt = 6'h00;
						nxt_st = MD_PREAMBLE;
					end
				end
			endcase
		end
	end

	// ==========================================
	// register writes, event latching and interrupt
	always_comb begin
		nxt_mask = mask_ff;
		nxt_port_interrupt_master_enable = port_interrupt_master_enable_ff;
		nxt_force_interrupt_test = force_interrupt_test_ff;
		nxt_sel = sel_ff;
		nxt_len = len_ff;
		nxt_str_en = str_en_ff;
		nxt_txc1 = txc1_ff;
		nxt_txc2 = txc2_ff;
		if (wr_strobe) begin
			unique case (reg_ff)
				`REG_INT_ENABLE: begin
					nxt_mask = nxt_sh[`IE_MASK_LSB +: 4];
					nxt_port_interrupt_master_enable = nxt_sh[`IE_MASTER_BIT];
					nxt_force_interrupt_test = nxt_sh[`IE_TEST_BIT];
				end
				`REG_LED_CONFIG: begin
					nxt_sel[0] = nxt_sh[`LED1_LSB +: 4];
					nxt_sel[1] = nxt_sh[`LED2_LSB +: 4];
					nxt_sel[2] = nxt_sh[`LED3_LSB +: 4];
					nxt_len = nxt_sh[`LED_LEN_LSB +: 2];
					nxt_str_en = nxt_sh[`LED_STRETCH_BIT];
				end
				`REG_TX_CTRL_ONE: nxt_txc1 = nxt_sh;
				`REG_TX_CTRL_TWO: nxt_txc2 = nxt_sh;
				default: nxt_mask = mask_ff;
			endcase
		end
		ev_set = {port_status.aneg_done & ~ang_prev_ff,
			port_status.speed_100 ^ spd_prev_ff,
			port_status.full_duplex ^ dpx_prev_ff,
			port_status.link_up ^ lnk_prev_ff};
		// read clears, but a new event in that cycle wins
		nxt_ev = (ev_ff & ~{4{rd_strobe && reg_ff == `REG_INT_STATUS}}) | ev_set;
		// masked latched event under master enable
		irq_cond = port_interrupt_master_enable_ff & (|(ev_ff & mask_ff));
		// pending flag, clear on read, set wins
		// judged on the next events, so a read is not undone by the old ones
		nxt_pend = (pend_ff & ~(rd_strobe && reg_ff == `REG_INT_STATUS))
			| (port_interrupt_master_enable_ff & (|(nxt_ev & mask_ff)));
		nxt_irq_n = ~(irq_cond | force_interrupt_test_ff);
	end

	// ==========================================
	// led displays with pulse stretching
	always_comb begin
		logic raw_ev;
		logic held;
		logic pri;
		logic on;
		raw_ev = 1'b0;
		held = 1'b0;
		pri = 1'b0;
		on = 1'b0;
		nxt_fast = (fast_ff == CW'(FAST_BLINK_CYCLES - 1)) ? '0 : fast_ff + CW'(1);
		nxt_fast_ph = (fast_ff == CW'(FAST_BLINK_CYCLES - 1)) ? ~fast_ph_ff : fast_ph_ff;
		nxt_slow = (slow_ff == CW'(SLOW_BLINK_CYCLES - 1)) ? '0 : slow_ff + CW'(1);
		nxt_slow_ph = (slow_ff == CW'(SLOW_BLINK_CYCLES - 1)) ? ~slow_ph_ff : slow_ph_ff;
		for (int i = 0; i < 3; i++) begin
			unique case (sel_ff[i])
				`LED_TX: raw_ev = port_status.tx_active;
				`LED_RX, `LED_LINK_RX: raw_ev = port_status.rx_active;
				`LED_COL, `LED_DPX_COL: raw_ev = port_status.collision;
				`LED_ACT, `LED_LINK_ACT: raw_ev = port_status.tx_active | port_status.rx_active;
				default: raw_ev = 1'b0;
			endcase
			if (raw_ev)
				nxt_scnt[i] = stretch_len(len_ff);
			else if (scnt_ff[i] != '0)
				nxt_scnt[i] = scnt_ff[i] - CW'(1);
			else
				nxt_scnt[i] = '0;
			held = raw_ev | (scnt_ff[i] != '0);
			pri = (sel_ff[i] == `LED_DPX_COL) ? port_status.full_duplex : port_status.link_up;
			unique case (sel_ff[i])
				// plain sources, stretch bit applies to event sources
				`LED_SPEED: on = port_status.speed_100;
				`LED_LINK: on = port_status.link_up;
				// duplex shown as reported, may lag link loss
				`LED_DUPLEX: on = port_status.full_duplex;
				`LED_TX, `LED_RX, `LED_COL, `LED_ACT: on = str_en_ff ? held : raw_ev;
				`LED_ON: on = 1'b1;
				`LED_OFF: on = 1'b0;
				`LED_FAST: on = fast_ph_ff;
				`LED_SLOW: on = slow_ph_ff;
				// primary solid, secondary flips it; always stretched
				`LED_LINK_RX, `LED_LINK_ACT, `LED_DPX_COL: on = pri ^ held;
				// reserved codes keep the led dark
				default: on = 1'b0;
			endcase
			nxt_led[i] = on ^ LED_ACTIVE_LOW;
		end
	end

	// ==========================================
	// registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_ff <= MD_PREAMBLE;
			cnt_ff <= 6'h00;
			sh_ff <= 16'h0000;
			reg_ff <= 5'h00;
			mdc_ff <= 1'b0;
			out_ff <= 1'b0;
			oe_ff <= 1'b0;
			match_ff <= 1'b0;
			mask_ff <= `IE_RESET;
			port_interrupt_master_enable_ff <= 1'b0;
			force_interrupt_test_ff <= 1'b0;
			ev_ff <= 4'h0;
			pend_ff <= 1'b0;
			sel_ff[0] <= `LED1_RESET;
			sel_ff[1] <= `LED2_RESET;
			sel_ff[2] <= `LED3_RESET;
			len_ff <= `LED_LEN_RESET;
			str_en_ff <= `LED_STRETCH_RESET;
			txc1_ff <= `TX_CTRL_RESET;
			txc2_ff <= `TX_CTRL_RESET;
			spd_prev_ff <= 1'b0;
			dpx_prev_ff <= 1'b0;
			lnk_prev_ff <= 1'b0;
			ang_prev_ff <= 1'b0;
			irq_n_ff <= 1'b1;
			scnt_ff <= '{default: '0};
			fast_ff <= '0;
			slow_ff <= '0;
			fast_ph_ff <= 1'b0;
			slow_ph_ff <= 1'b0;
			led_ff <= {3{LED_ACTIVE_LOW}};
		end else begin
			st_ff <= nxt_st;
			cnt_ff <= nxt_cnt;
			sh_ff <= nxt_sh;
			reg_ff <= nxt_reg;
			mdc_ff <= mdc;
			out_ff <= nxt_out;
			oe_ff <= nxt_oe;
			match_ff <= nxt_match;
			mask_ff <= nxt_mask;
			port_interrupt_master_enable_ff <= nxt_port_interrupt_master_enable;
			force_interrupt_test_ff <= nxt_force_interrupt_test;
			ev_ff <= nxt_ev;
			pend_ff <= nxt_pend;
			sel_ff <= nxt_sel;
			len_ff <= nxt_len;
			str_en_ff <= nxt_str_en;
			txc1_ff <= nxt_txc1;
			txc2_ff <= nxt_txc2;
			spd_prev_ff <= port_status.speed_100;
			dpx_prev_ff <= port_status.full_duplex;
			lnk_prev_ff <= port_status.link_up;
			ang_prev_ff <= port_status.aneg_done;
			irq_n_ff <= nxt_irq_n;
			scnt_ff <= nxt_scnt;
			fast_ff <= nxt_fast;
			slow_ff <= nxt_slow;
			fast_ph_ff <= nxt_fast_ph;
			slow_ph_ff <= nxt_slow_ph;
			led_ff <= nxt_led;
		end
	end

	assign mdio_out = out_ff;
	assign mdio_oe = oe_ff;
	assign management_interrupt_pending_n = irq_n_ff;
	assign led = led_ff;

endmodule

/* File: phy_port_regs_monitor.sv */
// pin level checks for the port register block
`timescale 1ns/10ps
module phy_port_regs_monitor
	import phy_port_pkg::*;
#(
	parameter int STRETCH0_CYCLES = 20
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [4:0] phy_address,
	input wire port_status_s port_status,
	input wire logic mdc,
	input wire logic mdio_in,
	input wire logic mdio_out,
	input wire logic mdio_oe,
	input wire logic management_interrupt_pending_n,
	input wire logic [2:0] led
);
	// ==========
	// helper state
	// quiet means no mdc rise yet, so every writable register still holds its reset value
	logic mdc_ff;
	logic quiet_ff;
	logic [4:0] rises_ff;
	logic [15:0] since_ff;
	logic rise;
	logic nxt_quiet;
	logic [4:0] nxt_rises;
	logic [15:0] nxt_since;
	assign rise = mdc & ~mdc_ff;
	always_comb begin
		nxt_quiet = quiet_ff & ~rise;
		nxt_rises = mdio_oe ? rises_ff + 5'(rise) : 5'h00;
		nxt_since = port_status.rx_active ? 16'h0000 : since_ff + 16'(since_ff != 16'hffff);
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mdc_ff <= 1'b0;
			quiet_ff <= 1'b1;
			rises_ff <= 5'h00;
			since_ff <= 16'hffff;
		end else begin
			mdc_ff <= mdc;
			quiet_ff <= nxt_quiet;
			rises_ff <= nxt_rises;
			since_ff <= nxt_since;
		end
	end
	// ==========
	// properties
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	property p_irq_quiet;
		quiet_ff |-> management_interrupt_pending_n;
	endproperty
	a_irq_quiet: assert property (p_irq_quiet) else $error("irq before setup");
	property p_led_speed;
		quiet_ff |-> led[0] == !$past(port_status.speed_100);
	endproperty
	a_led_speed: assert property (p_led_speed) else $error("led1 not speed");
	property p_led_link;
		quiet_ff |-> led[1] == !$past(port_status.link_up);
	endproperty
	a_led_link: assert property (p_led_link) else $error("led2 not link");
	property p_led_rx_on;
		quiet_ff && since_ff < STRETCH0_CYCLES - 2 |-> !led[2];
	endproperty
	a_led_rx_on: assert property (p_led_rx_on) else $error("rx led not stretched");
	property p_led_rx_off;
		quiet_ff && since_ff > STRETCH0_CYCLES + 3 |-> led[2];
	endproperty
	a_led_rx_off: assert property (p_led_rx_off) else $error("rx led stretched too long");
	property p_oe_ta;
		$rose(mdio_oe) |-> !mdio_out;
	endproperty
	a_oe_ta: assert property (p_oe_ta) else $error("turnaround not zero");
	property p_oe_len;
		$fell(mdio_oe) |-> rises_ff == 5'h11;
	endproperty
	a_oe_len: assert property (p_oe_len) else $error("read drive length wrong");
	property p_out_stable;
		mdio_oe && $past(mdio_oe) && !$past(rise) && !$past(rise, 2) |-> $stable(mdio_out);
	endproperty
	a_out_stable: assert property (p_out_stable) else $error("read bit changed mid bit");
	c_read: cover property ($fell(mdio_oe));
	c_irq: cover property ($fell(management_interrupt_pending_n));
	c_stretch: cover property (quiet_ff && since_ff == 16'h0001);
endmodule

bind phy_port_status_irq_led_regs phy_port_regs_monitor #(
	.STRETCH0_CYCLES(STRETCH0_CYCLES)
) u_phy_port_regs_monitor (.clk(clk), .rst_n(rst_n), .phy_address(phy_address),
	.port_status(port_status), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out),
	.mdio_oe(mdio_oe), .management_interrupt_pending_n(management_interrupt_pending_n), .led(led));

/* File: mdio_station_model.sv */
// management station model that runs mdio frames
`timescale 1ns/10ps
module mdio_station_model (
	input wire logic clk,
	input wire logic mdio_out,
	input wire logic mdio_oe,
	output logic mdc,
	output logic mdio_in
);
	logic drv;
	logic dq;
	// released line floats up through its pull-up
	assign mdio_in = mdio_oe ? mdio_out : (drv ? dq : 1'b1);
	initial begin
		mdc = 1'b0;
		drv = 1'b0;
		dq = 1'b1;
	end
	// ==========
	// one bit: two clocks low then two high, called at a falling clk edge
	task automatic bit_cycle(input logic d, output logic q);
		mdc = 1'b0;
		dq = d;
		repeat (2) @(negedge clk);
		q = mdio_in;
		mdc = 1'b1;
		repeat (2) @(negedge clk);
	endtask
	// ==========
	// whole frame; data sampled before the rise after the one that launched it
	task automatic frame(input logic wr, input logic [4:0] pa, input logic [4:0] ra,
		input logic [15:0] wd, output logic [15:0] rd);
		logic [13:0] hdr;
		logic q;
		hdr = {2'h1, wr ? 2'h1 : 2'h2, pa, ra};
		drv = 1'b1;
		for (int i = 0; i < 32; i++) bit_cycle(1'b1, q);
		for (int i = 13; i >= 0; i--) bit_cycle(hdr[i], q);
		drv = wr;
		bit_cycle(1'b1, q);
		bit_cycle(1'b0, q);
		for (int i = 15; i >= 0; i--) begin
			bit_cycle(wd[i], q);
			rd[i] = q;
		end
		mdc = 1'b0;
		drv = 1'b0;
		// one idle clock so a following frame never reassigns these in this step
		@(negedge clk);
	endtask
endmodule

/* File: tb_phy_port_status_irq_led_regs.sv */
// testbench for the port status, interrupt and led registers
`timescale 1ns/10ps
`include "phy_port_defines.svh"
module tb_phy_port_status_irq_led_regs
	import phy_port_pkg::*;
;
	localparam logic [4:0] PA = 5'h05;
	localparam int S0 = 20;
	// selector codes lit with link and full duplex up, all else idle
	localparam logic [15:0] LIT = 16'h7130;
	logic clk;
	logic rst_n;
	port_status_s st;
	logic mdc;
	logic mdio_in;
	logic mdio_out;
	logic mdio_oe;
	logic management_interrupt_pending_n;
	logic [2:0] led;
	logic [15:0] rdv;
	int num_errors;
	int comparisons;
	int n;
	phy_port_status_irq_led_regs #(.STRETCH0_CYCLES(S0), .STRETCH1_CYCLES(2 * S0),
		.STRETCH2_CYCLES(3 * S0), .FAST_BLINK_CYCLES(8), .SLOW_BLINK_CYCLES(16)
	) u_phy_port_status_irq_led_regs (.clk(clk), .rst_n(rst_n), .phy_address(PA),
		.port_status(st), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out),
		.mdio_oe(mdio_oe), .management_interrupt_pending_n(management_interrupt_pending_n), .led(led));
	mdio_station_model u_mdio_station_model (.clk(clk), .mdio_out(mdio_out),
		.mdio_oe(mdio_oe), .mdc(mdc), .mdio_in(mdio_in));
	always #12.5 clk = ~clk;
	// ==========
	// tasks
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic rd(input logic [4:0] ra, input logic [15:0] exp);
		u_mdio_station_model.frame(1'b0, PA, ra, 16'h0000, rdv);
		check(rdv, exp);
	endtask
	task automatic wr(input logic [4:0] ra, input logic [15:0] wd);
		u_mdio_station_model.frame(1'b1, PA, ra, wd, rdv);
	endtask
	task automatic tick(input int c);
		repeat (c) @(negedge clk);
	endtask
	task automatic summarize();
		$display("comparisons %0d errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// ==========
	// watchdog: whole run needs about a quarter of this
	initial begin
		#1000000;
		num_errors++;
		summarize();
	end
	// ==========
	// tests
	initial begin
		clk = 1'b0;
		rst_n = 1'b0;
		st = '0;
		num_errors = 0;
		comparisons = 0;
		tick(8);
		rst_n = 1'b1;
		tick(2);
		st.speed_100 = 1'b1;
		st.link_up = 1'b1;
		st.rx_active = 1'b1;
		tick(1);
		st.rx_active = 1'b0;
		tick(5);
		check(16'(led), 16'h0000);
		tick(40);
		check(16'(led), 16'h0004);
		$display("test led defaults done");
		rd(`REG_INT_STATUS, 16'h0050);
		rd(`REG_INT_STATUS, 16'h0000);
		rd(`REG_INT_ENABLE, 16'h0000);
		rd(`REG_LED_CONFIG, 16'h0422);
		$display("test reset values done");
		wr(`REG_INT_ENABLE, 16'h00f2);
		rd(`REG_INT_ENABLE, 16'h00f2);
		st.full_duplex = 1'b1;
		tick(4);
		check(16'(management_interrupt_pending_n), 16'h0000);
		rd(`REG_INT_STATUS, 16'h0024);
		tick(2);
		check(16'(management_interrupt_pending_n), 16'h0001);
		wr(`REG_INT_ENABLE, 16'h0002);
		st.link_up = 1'b0;
		tick(4);
		check(16'(management_interrupt_pending_n), 16'h0001);
		rd(`REG_INT_STATUS, 16'h0010);
		wr(`REG_INT_ENABLE, 16'h00f0);
		st.speed_100 = 1'b0;
		tick(4);
		check(16'(management_interrupt_pending_n), 16'h0001);
		rd(`REG_INT_STATUS, 16'h0040);
		wr(`REG_INT_ENABLE, 16'h0001);
		tick(2);
		check(16'(management_interrupt_pending_n), 16'h0000);
		rd(`REG_INT_STATUS, 16'h0000);
		wr(`REG_INT_ENABLE, 16'h0080);
		tick(2);
		check(16'(management_interrupt_pending_n), 16'h0001);
		st.aneg_done = 1'b1;
		tick(2);
		rd(`REG_INT_STATUS, 16'h0080);
		rd(`REG_INT_STATUS, 16'h0000);
		$display("test interrupts done");
		st = 11'h555;
		tick(2);
		wr(`REG_QUICK_STATUS, 16'hffff);
		rd(`REG_QUICK_STATUS, 16'h5528);
		st = 11'h2aa;
		tick(2);
		rd(`REG_QUICK_STATUS, 16'h2a90);
		$display("test quick status done");
		st = '0;
		st.link_up = 1'b1;
		st.full_duplex = 1'b1;
		for (n = 0; n < 16; n++) begin
			wr(`REG_LED_CONFIG, {n[3:0], 12'h420});
			tick(4);
			// blink codes have no fixed level at any one instant
			if (n != 10 && n != 11) begin
				check(16'(led[0]), 16'(!LIT[n]));
			end else begin
				rdv = 16'(led[0]);
				// one half period later the blinking led has flipped exactly once
				tick(n == 10 ? 8 : 16);
				check(16'(led[0]), 16'(!rdv[0]));
			end
		end
		wr(`REG_LED_CONFIG, 16'hc420);
		st.rx_active = 1'b1;
		tick(1);
		st.rx_active = 1'b0;
		tick(6);
		check(16'(led[0]), 16'h0001);
		tick(40);
		check(16'(led[0]), 16'h0000);
		$display("test led codes done");
		for (n = 0; n < 3; n++) begin
			wr(`REG_LED_CONFIG, {4'h2, 8'h42, n[1:0], 2'h2});
			st.rx_active = 1'b1;
			tick(1);
			st.rx_active = 1'b0;
			tick(S0 - 2 + S0 * n);
			check(16'(led[0]), 16'h0000);
			tick(6);
			check(16'(led[0]), 16'h0001);
		end
		$display("test stretch length done");
		summarize();
	end
endmodule
